// >>> core/pwseq_pkg.sv
/*
 * Package for the power/wake-up and OTP mirror sequencer: register map,
 * field positions, reset values, state encodings and timing constants.
 * Assumes a 100 MHz core clock and an AHB-Lite register port.
 */
package pwseq_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_MHZ         = 100;
	localparam int unsigned SETTLE_TMO_US   = 100;
	localparam int unsigned SETTLE_TMO_CYC  = SETTLE_TMO_US * CLK_MHZ;
	localparam int unsigned SEQ_MIN_US      = 1200;
	localparam int unsigned SEQ_MAX_US      = 1500;
	localparam int unsigned SEQ_MIN_CYC     = SEQ_MIN_US * CLK_MHZ;
	localparam int unsigned SEQ_MAX_CYC     = SEQ_MAX_US * CLK_MHZ;
	localparam int unsigned MIRROR_TYP_US   = 1200;
	localparam int unsigned OTP_BYTES       = 32768;
	localparam int unsigned OTP_WORDS       = OTP_BYTES / 4;

	// ****************************************************************
	// Register map (byte addresses)
	// ****************************************************************
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] COUNT_OFS  = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [7:0] FLAG1_OFS  = 8'h0c;
	localparam logic [7:0] FLAG2_OFS  = 8'h10;
	localparam logic [7:0] BOOT_OFS   = 8'h14;

	// Control fields
	localparam int unsigned CTRL_TMO_DIS_BIT  = 0;
	localparam int unsigned CTRL_COPY_EN_BIT  = 1;
	localparam int unsigned CTRL_REMAP_BIT    = 2;
	localparam int unsigned CTRL_SW_RESET_BIT = 3;
	localparam logic [3:0]  CTRL_RST          = 4'h0;

	// Header flag words and length field
	localparam logic [31:0] APP_FLAG1     = 32'h1234a5a5;
	localparam logic [31:0] APP_FLAG2     = 32'ha5a51234;
	localparam logic [14:0] HDR_LEN_ADDR  = 15'h7ff8;
	localparam logic [13:0] COUNT_RST     = 14'h0000;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [3:0] {
		PS_IDLE    = 4'b0000,
		PS_BOOST   = 4'b0001,
		PS_REGS    = 4'b0011,
		PS_REG_WT  = 4'b0010,
		PS_XTAL    = 4'b0110,
		PS_XTAL_WT = 4'b0111,
		PS_HAND    = 4'b0101,
		PS_MIRROR  = 4'b0100,
		PS_RUN     = 4'b1100
	} pwseq_state_t;

	typedef enum logic [1:0] {
		BM_NONE   = 2'b00,
		BM_NORMAL = 2'b01,
		BM_DEVEL  = 2'b11,
		BM_BROKEN = 2'b10
	} pwseq_boot_t;

	typedef struct packed {
		logic buck_ok;
		logic boost_ok;
		logic reg_settled;
		logic xtal_settled;
	} pwseq_ana_in_t;

	typedef struct packed {
		logic dcdc_en;
		logic dcdc_boost;
		logic bandgap_en;
		logic core_ldo_en;
		logic otp_ldo_en;
		logic xtal_en;
	} pwseq_ana_out_t;

	typedef struct packed {
		logic        rd;
		logic [14:0] addr;
	} pwseq_otp_req_t;

	typedef struct packed {
		logic        wr;
		logic [14:0] addr;
		logic [31:0] data;
	} pwseq_ram_wr_t;

endpackage : pwseq_pkg

// >>> core/pwseq_top.sv
/*
 * Power/wake-up sequencer with hardware OTP-to-system-RAM mirror engine
 * and boot mode classification. AHB-Lite slave for its registers.
 * Assumes comparator and settle inputs synchronous to core_clk, an OTP
 * that answers a read request on the next cycle, and that cold_power_up
 * pulses once per power-on while wake_up pulses once per sleep exit.
 */
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
module pwseq_top
	import pwseq_pkg::*;
#(
	parameter int unsigned TMO_CYC = SETTLE_TMO_CYC,
	parameter int unsigned CNT_W   = 14
) (
	input  wire logic                       core_clk,
	input  wire logic                       reset_n,
	input  wire logic                       cold_power_up,
	input  wire logic                       wake_up,
	input  wire pwseq_pkg::pwseq_ana_in_t   ana_in,
	output pwseq_pkg::pwseq_ana_out_t       ana_out,
	output pwseq_pkg::pwseq_otp_req_t       otp_req,
	input  wire logic [31:0]                otp_rdata,
	output pwseq_pkg::pwseq_ram_wr_t        ram_wr,
	output logic                            cpu_run,
	output logic                            boot_rom_go,
	output logic                            periph_en,
	output logic                            zero_address_map_select,
	output logic                            sw_reset,
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic [31:0]                     hrdata,
	output logic                            hreadyout,
	output logic                            hresp
);
	import pwseq_pkg::*;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	pwseq_state_t     st_q;
	logic             cold_q;
	logic [3:0]       ctrl_q;
	logic [CNT_W-1:0] count_q;
	logic [31:0]      flag1_q;
	logic [31:0]      flag2_q;
	logic [3:0]       dev_step_q;
	logic             step_ok_q;
	logic [31:0]      tmo_q;
	logic [CNT_W-1:0] mir_idx_q;
	logic             mir_pend_q;
	logic             wr_pend_q;
	logic [7:0]       wr_addr_q;
	logic [14:0]      rd_addr_q;
	logic             boost_q;
	pwseq_ana_out_t   ana_q;

	wire logic tmo_dis  = ctrl_q[CTRL_TMO_DIS_BIT];
	wire logic copy_en  = ctrl_q[CTRL_COPY_EN_BIT];
	wire logic start    = cold_power_up | wake_up;
	wire logic tmo_hit  = !tmo_dis && (tmo_q >= TMO_CYC - 1);

	function automatic pwseq_boot_t classify(input logic [31:0] f1, input logic [31:0] f2);
		if (f1 == APP_FLAG1 && f2 == APP_FLAG2)
			return BM_NORMAL;
		else if (f1 == 32'h0000_0000 && f2 == 32'h0000_0000)
			return BM_DEVEL;
		else
			return BM_BROKEN;
	endfunction : classify

	wire pwseq_boot_t boot_mode = cold_q ? classify(flag1_q, flag2_q) : BM_NONE;

	// ****************************************************************
	// Cold-start flag
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (!reset_n)
			cold_q <= 1'b1;
		else if (cold_power_up)
			cold_q <= 1'b1;
		else if (wake_up)
			cold_q <= 1'b0;
	end

	// ****************************************************************
	// Power/wake-up state machine
	// ****************************************************************
	// Timeout counter restarts in PS_REGS and PS_XTAL, so each settle
	// wait gets its own budget.
	always_ff @(posedge core_clk) begin
		if (!reset_n)
			st_q <= PS_IDLE;
		else if (start)
			st_q <= PS_BOOST;
		else begin
			case (st_q)
				PS_IDLE:    st_q <= PS_IDLE;
				PS_BOOST:   st_q <= PS_REGS;
				PS_REGS:    st_q <= PS_REG_WT;
				PS_REG_WT:  if (ana_in.reg_settled || tmo_hit)
					st_q <= PS_XTAL;
				PS_XTAL:    st_q <= PS_XTAL_WT;
				PS_XTAL_WT: if (ana_in.xtal_settled || tmo_hit)
					st_q <= PS_HAND;
				PS_HAND:    st_q <= (!cold_q && copy_en && count_q != '0)
					? PS_MIRROR : PS_RUN;
				// Leave once the last word is back from the OTP; its RAM write lands in the first PS_RUN cycle
				PS_MIRROR:  if (wr_pend_q && mir_idx_q == count_q && mir_pend_q && !otp_req.rd)
					st_q <= PS_RUN;
				PS_RUN:     st_q <= PS_RUN;
				default:    st_q <= PS_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n || start || st_q == PS_REGS || st_q == PS_XTAL)
			tmo_q <= '0;
		else if (tmo_q != 32'hffff_ffff)
			tmo_q <= tmo_q + 32'd1;
	end

	// ****************************************************************
	// Analog enables
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (!reset_n || start) begin
			ana_q   <= '0;
			boost_q <= 1'b0;
		end else begin
			case (st_q)
				PS_BOOST: if (ana_in.boost_ok) begin
					ana_q.dcdc_en    <= 1'b1;
					ana_q.dcdc_boost <= 1'b1;
					boost_q          <= 1'b1;
				end
				PS_REGS: begin
					ana_q.bandgap_en  <= 1'b1;
					ana_q.core_ldo_en <= 1'b1;
					ana_q.otp_ldo_en  <= 1'b1;
				end
				PS_XTAL: begin
					ana_q.xtal_en <= 1'b1;
					// Second check: buck wins when the high input is present
					ana_q.dcdc_en    <= ana_in.buck_ok | ana_in.boost_ok;
					ana_q.dcdc_boost <= !ana_in.buck_ok & ana_in.boost_ok;
				end
				default: ana_q <= ana_q;
			endcase
		end
	end
	assign ana_out = ana_q;

	// ****************************************************************
	// Hardware mirror engine
	// ****************************************************************
	// OTP read is issued one cycle, data written to RAM two cycles later; words
	// stream one per cycle after the first.
	always_ff @(posedge core_clk) begin
		if (!reset_n || st_q != PS_MIRROR) begin
			mir_idx_q  <= '0;
			mir_pend_q <= 1'b0;
			wr_pend_q  <= 1'b0;
		end else begin
			wr_pend_q  <= 1'b1;
			mir_pend_q <= otp_req.rd;
			if (mir_idx_q != count_q)
				mir_idx_q <= mir_idx_q + 1'b1;
		end
	end

	// Address delayed to line up with the word the OTP returns a cycle later
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			ram_wr    <= '0;
			rd_addr_q <= '0;
		end else begin
			rd_addr_q   <= otp_req.addr;
			ram_wr.wr   <= mir_pend_q;
			ram_wr.addr <= rd_addr_q;
			ram_wr.data <= otp_rdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n)
			otp_req <= '0;
		else begin
			otp_req.rd   <= (st_q == PS_MIRROR) && (mir_idx_q != count_q);
			otp_req.addr <= {mir_idx_q[12:0], 2'b00};
		end
	end

	// ****************************************************************
	// Hand-off outputs
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (!reset_n || start) begin
			cpu_run     <= 1'b0;
			boot_rom_go <= 1'b0;
		end else if (st_q == PS_RUN) begin
			cpu_run     <= 1'b1;
			boot_rom_go <= cold_q;
		end
	end

	assign periph_en = cpu_run && cold_q && boot_mode != BM_NORMAL;
	assign zero_address_map_select = ctrl_q[CTRL_REMAP_BIT];
	assign sw_reset = ctrl_q[CTRL_SW_RESET_BIT];

	// ****************************************************************
	// AHB-Lite slave
	// ****************************************************************
	wire logic ahb_go = hsel && hready && htrans[1];
	logic      wr_q;

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			wr_q      <= 1'b0;
			wr_addr_q <= '0;
		end else begin
			wr_q      <= ahb_go && hwrite;
			wr_addr_q <= haddr[7:0];
		end
	end

	// Software reset bit self-clears so a single write fires once.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			ctrl_q     <= CTRL_RST;
			count_q    <= COUNT_RST;
			flag1_q    <= '0;
			flag2_q    <= '0;
			dev_step_q <= '0;
			step_ok_q  <= 1'b0;
		end else begin
			ctrl_q[CTRL_SW_RESET_BIT] <= 1'b0;
			if (wr_q) begin
				case (wr_addr_q)
					CTRL_OFS:  ctrl_q  <= hwdata[3:0];
					COUNT_OFS: count_q <= hwdata[CNT_W-1:0];
					FLAG1_OFS: flag1_q <= hwdata;
					FLAG2_OFS: flag2_q <= hwdata;
					BOOT_OFS: begin
						// Step advances on timeout, stops on reply
						step_ok_q <= hwdata[4];
						if (!hwdata[4] && dev_step_q != 4'd10)
							dev_step_q <= dev_step_q + 4'd1;
					end
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n)
			hrdata <= '0;
		else if (ahb_go && !hwrite) begin
			case (haddr[7:0])
				CTRL_OFS:   hrdata <= {28'h0, ctrl_q};
				COUNT_OFS:  hrdata <= {{(32-CNT_W){1'b0}}, count_q};
				STATUS_OFS: hrdata <= {24'h0, boost_q, cold_q, boot_mode, st_q};
				FLAG1_OFS:  hrdata <= flag1_q;
				FLAG2_OFS:  hrdata <= flag2_q;
				BOOT_OFS:   hrdata <= {27'h0, step_ok_q, dev_step_q};
				default:    hrdata <= '0;
			endcase
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	wire logic [15:0] wt_u = 16'(tmo_q);

	cold_flag_set_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		cold_power_up |=> cold_q) else $error("cold flag not set");
	seq_start_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		start |=> st_q == PS_BOOST) else $error("sequence not started");
	boost_first_a: assert property (@(posedge core_clk) disable iff (!reset_n || start)
		st_q == PS_BOOST && ana_in.boost_ok |=> ana_out.dcdc_boost && !ana_out.bandgap_en)
		else $error("boost not first");
	regs_on_a: assert property (@(posedge core_clk) disable iff (!reset_n || start)
		st_q == PS_REGS |=> ana_out.bandgap_en && ana_out.core_ldo_en && ana_out.otp_ldo_en)
		else $error("regulators not enabled");
	xtal_on_a: assert property (@(posedge core_clk) disable iff (!reset_n || start)
		st_q == PS_XTAL |=> ana_out.xtal_en && ana_out.dcdc_boost == $past(!ana_in.buck_ok
		&& ana_in.boost_ok)) else $error("crystal or mode check wrong");
	settle_tmo_a: assert property (@(posedge core_clk) disable iff (!reset_n || start)
		st_q == PS_REG_WT && tmo_hit |=> st_q == PS_XTAL) else $error("timeout ignored");
	tmo_dis_a: assert property (@(posedge core_clk) disable iff (!reset_n || start)
		st_q == PS_XTAL_WT && tmo_dis && !ana_in.xtal_settled |=> st_q == PS_XTAL_WT)
		else $error("waited not forever");
	wake_no_rom_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		boot_rom_go |-> cold_q) else $error("boot rom on wake");
	hand_mirror_a: assert property (@(posedge core_clk) disable iff (!reset_n || start)
		st_q == PS_HAND && !cold_q && copy_en && count_q != '0 |=> st_q == PS_MIRROR)
		else $error("mirror not taken");
	cpu_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		cpu_run |-> st_q == PS_RUN) else $error("cpu ran early");
	mirror_len_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		otp_req.rd |-> {1'b0, otp_req.addr[14:2]} < count_q) else $error("over-read");
	normal_mode_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		cold_q && flag1_q == APP_FLAG1 && flag2_q == APP_FLAG2 |-> boot_mode == BM_NORMAL)
		else $error("normal not selected");
	step_cap_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		dev_step_q <= 4'd10) else $error("step past ten");

	wake_mirror_c: cover property (@(posedge core_clk) disable iff (!reset_n)
		st_q == PS_MIRROR ##1 st_q == PS_RUN);
	cold_boot_c: cover property (@(posedge core_clk) disable iff (!reset_n)
		$rose(boot_rom_go));
	timeout_c: cover property (@(posedge core_clk) disable iff (!reset_n)
		st_q == PS_XTAL_WT && tmo_hit && wt_u != 16'h0);

endmodule : pwseq_top

// >>> verif/pwseq_far_model.sv
/*
 * Far-side model: supply comparators, regulator and crystal settle flags,
 * and the OTP array answering word reads.
 * Assumes the sequencer's ana_out and otp_req change on core_clk edges.
 */
`timescale 1ns/1ns
module pwseq_far_model (
	input  wire logic                      core_clk,
	input  wire logic                      boost_cmp,
	input  wire logic                      buck_cmp,
	input  wire logic                      never_settle,
	input  wire logic [7:0]                settle_dly,
	input  wire pwseq_pkg::pwseq_ana_out_t ana_out,
	input  wire pwseq_pkg::pwseq_otp_req_t otp_req,
	output pwseq_pkg::pwseq_ana_in_t       ana_in,
	output logic [31:0]                    otp_rdata
);
	import pwseq_pkg::*;

	// ****************************************************************
	// Settle flags and OTP array
	// ****************************************************************
	logic       reg_on;
	logic [7:0] reg_cnt_q = 8'h00;
	logic [7:0] xtal_cnt_q = 8'h00;

	assign reg_on = ana_out.bandgap_en && ana_out.core_ldo_en && ana_out.otp_ldo_en;

	// Counts saturate so a long wait never wraps back to unsettled
	always_ff @(posedge core_clk) begin
		reg_cnt_q <= reg_on ? reg_cnt_q + {7'h00, reg_cnt_q != 8'hff} : 8'h00;
		xtal_cnt_q <= ana_out.xtal_en ? xtal_cnt_q + {7'h00, xtal_cnt_q != 8'hff} : 8'h00;
	end

	assign ana_in.boost_ok = boost_cmp;
	assign ana_in.buck_ok = buck_cmp;
	assign ana_in.reg_settled = !never_settle && reg_on && reg_cnt_q >= settle_dly;
	assign ana_in.xtal_settled = !never_settle && ana_out.xtal_en && xtal_cnt_q >= settle_dly;

	// Lines toggle outside a read so stale data never looks valid
	always_ff @(posedge core_clk) begin
		if (otp_req.rd)
			otp_rdata <= 32'h5a5a0000 | {17'h00000, otp_req.addr};
		else
			otp_rdata <= ~otp_rdata;
	end
endmodule : pwseq_far_model

// >>> verif/pwseq_top_tb.sv
/*
 * Self-checking bench for the start-up sequencer: cold start, timeouts,
 * wake mirror, boot modes and control bits over AHB-Lite.
 * Assumes pwseq_far_model stands in for the analog blocks and OTP.
 */
`timescale 1ns/1ns
module pwseq_top_tb;
	import pwseq_pkg::*;

	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	logic           core_clk;
	logic           reset_n;
	logic           cold_power_up;
	logic           wake_up;
	pwseq_ana_in_t  ana_in;
	pwseq_ana_out_t ana_out;
	pwseq_otp_req_t otp_req;
	logic [31:0]    otp_rdata;
	pwseq_ram_wr_t  ram_wr;
	logic           cpu_run;
	logic           boot_rom_go;
	logic           periph_en;
	logic           zams;
	logic           sw_reset;
	logic           hsel;
	logic [31:0]    haddr;
	logic [1:0]     htrans;
	logic           hwrite;
	logic [2:0]     hsize;
	logic [31:0]    hwdata;
	logic [31:0]    hrdata;
	logic           hreadyout;
	logic           hresp;
	logic           boost_cmp;
	logic           buck_cmp;
	logic           never_settle;
	logic [7:0]     settle_dly;
	logic [31:0]    rd;
	int             n_errors = 0;
	int             checked = 0;
	int             n_wr = 0;

	pwseq_top #(.TMO_CYC(20)) dut (.core_clk(core_clk), .reset_n(reset_n),
		.cold_power_up(cold_power_up), .wake_up(wake_up), .ana_in(ana_in),
		.ana_out(ana_out), .otp_req(otp_req), .otp_rdata(otp_rdata), .ram_wr(ram_wr),
		.cpu_run(cpu_run), .boot_rom_go(boot_rom_go), .periph_en(periph_en),
		.zero_address_map_select(zams), .sw_reset(sw_reset), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp));

	pwseq_far_model far (.core_clk(core_clk), .boost_cmp(boost_cmp),
		.buck_cmp(buck_cmp), .never_settle(never_settle), .settle_dly(settle_dly),
		.ana_out(ana_out), .otp_req(otp_req), .ana_in(ana_in), .otp_rdata(otp_rdata));

	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic complete_run();
		if (n_errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic give_up(input string what);
		chk(32'h0, 32'h1, what);
		complete_run();
	endtask : give_up

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		htrans <= 2'b10;
		for (int ph = 0; ph < 2; ph++) begin
			n = 0;
			do begin
				@(posedge core_clk);
				n++;
			end while (hreadyout !== 1'b1 && n < 20);
			if (n >= 20)
				give_up("bus wait");
			if (ph == 0) begin
				htrans <= 2'b00;
				hsel <= 1'b0;
				hwdata <= wd;
			end
		end
		rd = hrdata;
	endtask : bus

	task automatic start(input logic cold);
		cold_power_up <= cold;
		wake_up <= !cold;
		@(posedge core_clk);
		cold_power_up <= 1'b0;
		wake_up <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk(cpu_run, 1'b0, "cpu held");
	endtask : start

	task automatic wait_run(input int limit);
		int n;
		n = 0;
		while (cpu_run !== 1'b1 && n < limit) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= limit)
			give_up("cpu_run wait");
	endtask : wait_run

	// Mirror writes in address order, with the processor still held
	always @(posedge core_clk) begin
		if (ram_wr.wr === 1'b1) begin
			chk({17'h00000, ram_wr.addr}, 32'(n_wr * 4), "mirror addr");
			chk(ram_wr.data, 32'h5a5a0000 | 32'(n_wr * 4), "mirror data");
			chk(cpu_run, 1'b0, "cpu during mirror");
			n_wr++;
		end
	end

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		chk({cpu_run, boot_rom_go, ana_out}, 8'h00, "reset outputs");
		bus(1'b0, STATUS_OFS, 32'h0);
		chk({rd[6], rd[3:0]}, {1'b1, PS_IDLE}, "cold flag");
		bus(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		bus(1'b0, CTRL_OFS, 32'h0);
		chk(rd, 32'h0, "ctrl reset");
		chk(hresp, 1'b0, "okay response");
	endtask : t_reset

	task automatic t_cold();
		boost_cmp <= 1'b1;
		n_wr = 0;
		start(1'b1);
		wait_run(200);
		chk(ana_out, 6'h3f, "supplies on");
		chk(boot_rom_go, 1'b1, "boot rom on cold");
		chk(n_wr, 0, "no hw mirror on cold");
		bus(1'b0, STATUS_OFS, 32'h0);
		chk({rd[7:6], rd[3:0]}, {2'b11, PS_RUN}, "cold status");
	endtask : t_cold

	task automatic t_modes();
		logic [31:0] f1[3] = '{APP_FLAG1, 32'h3c3c3c3c, 32'h0};
		logic [31:0] f2[3] = '{APP_FLAG2, APP_FLAG2, 32'h0};
		pwseq_boot_t md[3] = '{BM_NORMAL, BM_BROKEN, BM_DEVEL};
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, FLAG1_OFS, f1[i]);
			bus(1'b1, FLAG2_OFS, f2[i]);
			bus(1'b0, STATUS_OFS, 32'h0);
			chk(rd[5:4], md[i], "boot mode");
			chk(periph_en, md[i] != BM_NORMAL, "peripherals");
		end
	endtask : t_modes

	task automatic t_search();
		bus(1'b1, BOOT_OFS, 32'h10);
		bus(1'b0, BOOT_OFS, 32'h0);
		chk(rd[4:0], 5'h10, "reply holds step");
		repeat (12) bus(1'b1, BOOT_OFS, 32'h0);
		bus(1'b0, BOOT_OFS, 32'h0);
		chk(rd[3:0], 4'd10, "last search step");
	endtask : t_search

	task automatic t_ctrl();
		int n;
		bus(1'b1, CTRL_OFS, 32'h4);
		@(posedge core_clk);
		chk(zams, 1'b1, "remap on");
		bus(1'b1, CTRL_OFS, 32'hc);
		n = 0;
		while (sw_reset !== 1'b1 && n < 5) begin
			@(posedge core_clk);
			n++;
		end
		chk(n < 5, 1'b1, "software reset pulse");
		bus(1'b0, CTRL_OFS, 32'h0);
		chk(rd[3:0], 4'h4, "reset bit clears");
		bus(1'b1, CTRL_OFS, 32'h0);
		@(posedge core_clk);
		chk(zams, 1'b0, "remap off");
	endtask : t_ctrl

	task automatic t_timeout();
		never_settle <= 1'b1;
		start(1'b1);
		wait_run(100);
		chk(ana_out.xtal_en, 1'b1, "continues after timeout");
		bus(1'b1, CTRL_OFS, 32'h1);
		start(1'b1);
		repeat (200) @(posedge core_clk);
		chk(cpu_run, 1'b0, "waits without timeout");
		never_settle <= 1'b0;
		wait_run(50);
	endtask : t_timeout

	task automatic t_wake();
		logic [13:0] cnt[4] = '{14'd5, 14'd5, 14'd0, 14'(OTP_WORDS)};
		logic [1:0]  cp[4] = '{2'b10, 2'b00, 2'b10, 2'b10};
		boost_cmp <= 1'b0;
		buck_cmp <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, COUNT_OFS, {18'h0, cnt[i]});
			bus(1'b1, CTRL_OFS, {30'h0, cp[i]});
			n_wr = 0;
			start(1'b0);
			wait_run(9000);
			chk(n_wr, cp[i][1] ? 32'(cnt[i]) : 32'h0, "words mirrored");
			chk({boot_rom_go, ana_out.dcdc_boost}, 2'b00, "wake hand-off");
			bus(1'b0, COUNT_OFS, 32'h0);
			chk(rd[13:0], cnt[i], "count retained");
			bus(1'b0, STATUS_OFS, 32'h0);
			chk(rd[6], 1'b0, "wake clears cold flag");
		end
	endtask : t_wake

	initial begin
		reset_n = 1'b0;
		{cold_power_up, wake_up, hsel, hwrite, boost_cmp, buck_cmp, never_settle} = 7'h0;
		{haddr, hwdata} = 64'h0;
		htrans = 2'b00;
		hsize = 3'b010;
		settle_dly = 8'h03;
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_cold();
		t_modes();
		t_search();
		t_ctrl();
		t_timeout();
		t_wake();
		complete_run();
	end

	initial begin
		repeat (60000) @(posedge core_clk);
		give_up("run limit");
	end
endmodule : pwseq_top_tb
